//--- hdl/sltem_monitor.sv
// Lane PRBS, transport sample, CGS and error counter test monitor
// Behaviour
// - Pattern select picks PRBS7, PRBS15 or PRBS31
// - PRBS checks raw lane bits, no alignment
// - One enable bit per physical lane
// - Clear pulse wipes checker, pass, counts
// - Start rising edge runs, clear stops
// - Twenty-four bit PRBS error limit, three bytes
// - Pass byte, one bit per lane
// - Lane select picks read-back error count
// - PRBS error counters saturate at all ones
// - Converter and sample select pick compared slot
// - Expected sample low byte at lower address
// - Transport enable, then clear pulse before reading
// - Mismatch bit: one on mismatch
// - Commas pass CGS, sync released
// - ILAS mode: sync released after four commas
// - Link page maps lane x to x+4
// - Disparity counts include not-in-table characters
// - Select lane and type, read count
// - Error counters stop at shared threshold
// - One threshold, three over-threshold registers
// - Control write: clear IRQ, disable, clear count
// - Three IRQ enables, status same bits
`timescale 1ns/1ps
`include "sltem_regs.svh"

module sltem_monitor #(
  parameter int LANES = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [11:0]          reg_addr,
  input  wire logic                 reg_wr,
  input  wire sltem_pkg::sltem_byte_t reg_wdata,
  output sltem_pkg::sltem_byte_t    reg_rdata,
  input  wire logic [LANES-1:0]     lane_bit,
  input  wire logic [LANES-1:0]     disp_err,
  input  wire logic [LANES-1:0]     nit_err,
  input  wire logic [LANES-1:0]     ucc_err,
  input  wire logic [15:0]          tpl_sample,
  input  wire logic [1:0]           tpl_conv,
  input  wire logic [1:0]           tpl_slot,
  input  wire logic                 tpl_valid,
  input  wire logic [LANES-1:0]     comma_seen,
  input  wire logic [LANES-1:0]     lane_in_use,
  input  wire logic                 link_enable,
  output logic                      sync_request_output_n,
  output logic                      ilas_test_mode
);
  import sltem_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] map_lane(input logic page,
                                          input logic [2:0] lane);
    map_lane = 3'(lane + {page, 2'b00});
  endfunction

  function automatic sltem_byte_t page_view(input logic page,
                                            input sltem_byte_t v);
    page_view = page ? {4'h0, v[7:4]} : v;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic        link_page;
  sltem_byte_t prbs_lane_enable;
  sltem_byte_t prbs_test_control;
  logic [23:0] prbs_error_limit;
  sltem_byte_t transport_test_control;
  logic [15:0] transport_expected_sample;
  sltem_byte_t count_sel;
  logic [2:0]  irq_enable;
  sltem_byte_t shared_error_threshold;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link_page                 <= 1'b0;
      prbs_lane_enable          <= 8'h00;
      prbs_test_control         <= 8'h00;
      prbs_error_limit          <= 24'h000000;
      transport_test_control    <= 8'h00;
      transport_expected_sample <= 16'h0000;
      count_sel                 <= 8'h00;
      irq_enable                <= 3'h0;
      ilas_test_mode            <= 1'b0;
      shared_error_threshold    <= `SLTEM_THR_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `SLTEM_LINK_PAGE:  link_page <= reg_wdata[`SLTEM_PAGE_BIT];
        `SLTEM_PRBS_EN:    prbs_lane_enable <= reg_wdata;
        `SLTEM_PRBS_CTRL:  prbs_test_control <= reg_wdata;
        `SLTEM_PRBS_LIM0:  prbs_error_limit[7:0] <= reg_wdata;
        `SLTEM_PRBS_LIM1:  prbs_error_limit[15:8] <= reg_wdata;
        `SLTEM_PRBS_LIM2:  prbs_error_limit[23:16] <= reg_wdata;
        `SLTEM_TPL_CTRL:   transport_test_control <= reg_wdata;
        `SLTEM_TPL_EXP_LO: transport_expected_sample[7:0] <= reg_wdata;
        `SLTEM_TPL_EXP_HI: transport_expected_sample[15:8] <= reg_wdata;
        `SLTEM_CNT_SEL:    count_sel <= reg_wdata;
        `SLTEM_ILAS_MODE:  ilas_test_mode <= reg_wdata[`SLTEM_ILAS_BIT];
        `SLTEM_IRQ_EN:     irq_enable <= reg_wdata[7:5];
        `SLTEM_ERR_THR:    shared_error_threshold <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // PRBS checker
  // ----------------------------------------
  logic        prbs_clear;
  logic        start_bit;
  logic        start_q;
  logic        prbs_running;
  logic [30:0] prbs_hist [LANES];
  logic [4:0]  seed_cnt [LANES];
  logic [23:0] prbs_error_count [LANES];
  sltem_byte_t prbs_lane_pass;
  sltem_pat_t  pat;
  logic [LANES-1:0] prbs_bad;
  logic [LANES-1:0] prbs_exp;

  assign prbs_clear = prbs_test_control[`SLTEM_CLR_BIT];
  assign start_bit  = prbs_test_control[`SLTEM_START_BIT];
  assign pat        = sltem_pat_t'(prbs_test_control[3:2]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      start_q      <= 1'b0;
      prbs_running <= 1'b0;
    end else begin
      start_q <= start_bit;
      if (prbs_clear || !start_bit)
        prbs_running <= 1'b0;
      else if (!start_q)
        prbs_running <= 1'b1;
    end
  end

  // Seeded from the line, then free-running so one bad bit counts once
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      unique case (pat)
        SLTEM_PAT7:  prbs_exp[i] = prbs_hist[i][6] ^ prbs_hist[i][5];
        SLTEM_PAT15: prbs_exp[i] = prbs_hist[i][14] ^ prbs_hist[i][13];
        SLTEM_PAT31: prbs_exp[i] = prbs_hist[i][30] ^ prbs_hist[i][27];
        default:     prbs_exp[i] = lane_bit[i];
      endcase
      if (seed_cnt[i] != `SLTEM_SEED_BITS) prbs_exp[i] = lane_bit[i];
      prbs_bad[i] = prbs_running && prbs_lane_enable[i] &&
                    seed_cnt[i] == `SLTEM_SEED_BITS &&
                    prbs_exp[i] != lane_bit[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (sys_rst || prbs_clear) begin
        prbs_hist[i]        <= 31'h0;
        seed_cnt[i]         <= 5'h0;
        prbs_error_count[i] <= 24'h000000;
      end else begin
        prbs_hist[i] <= {prbs_hist[i][29:0], prbs_exp[i]};
        if (prbs_lane_enable[i] && seed_cnt[i] != `SLTEM_SEED_BITS)
          seed_cnt[i] <= seed_cnt[i] + 5'h1;
        if (prbs_bad[i] && prbs_error_count[i] != `SLTEM_PRBS_MAX)
          prbs_error_count[i] <= prbs_error_count[i] + 24'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || prbs_clear) begin
      prbs_lane_pass <= 8'h00;
    end else if (prbs_running && !start_bit) begin
      for (int i = 0; i < LANES; i++)
        prbs_lane_pass[i] <= prbs_error_count[i] <= prbs_error_limit;
    end
  end

  // ----------------------------------------
  // Transport layer sample check
  // ----------------------------------------
  logic tpl_enable;
  logic tpl_clear;
  logic transport_test_mismatch;

  assign tpl_enable = transport_test_control[0];
  assign tpl_clear  = transport_test_control[1];

  always_ff @(posedge sys_clk) begin
    if (sys_rst || tpl_clear) begin
      transport_test_mismatch <= 1'b0;
    end else if (tpl_enable && tpl_valid &&
                 tpl_conv == transport_test_control[3:2] &&
                 tpl_slot == transport_test_control[5:4] &&
                 tpl_sample != transport_expected_sample) begin
      transport_test_mismatch <= 1'b1;
    end
  end

  // ----------------------------------------
  // Code group sync
  // ----------------------------------------
  logic [2:0]       comma_cnt [LANES];
  logic [LANES-1:0] cgs_pass;

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (sys_rst || !link_enable)
        comma_cnt[i] <= 3'h0;
      else if (comma_seen[i] && comma_cnt[i] != `SLTEM_COMMA_NEED)
        comma_cnt[i] <= comma_cnt[i] + 3'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < LANES; i++)
      cgs_pass[i] = comma_cnt[i] == `SLTEM_COMMA_NEED;
  end

  // Held low until every lane in use saw four commas
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      sync_request_output_n <= 1'b0;
    else
      sync_request_output_n <= link_enable &&
                               &(cgs_pass | ~lane_in_use);
  end

  // ----------------------------------------
  // Link error counters
  // ----------------------------------------
  logic [LANES-1:0] err_in [3];
  sltem_byte_t      err_cnt [3][LANES];
  logic [LANES-1:0] cnt_disable [3];
  logic [LANES-1:0] lane_irq [3];
  logic [LANES-1:0] over_thr [3];
  logic [11:0]      ctl_off;
  logic             ctl_hit;
  logic [2:0]       ctl_lane;

  // Disparity input flags every bad-disparity char, table or not
  assign err_in[0] = disp_err;
  assign err_in[1] = nit_err;
  assign err_in[2] = ucc_err;
  assign ctl_off   = reg_addr - `SLTEM_OVER_DISP;
  assign ctl_hit   = reg_wr && ctl_off < 12'h003;
  assign ctl_lane  = map_lane(link_page, reg_wdata[2:0]);

  always_comb begin
    for (int t = 0; t < 3; t++)
      for (int l = 0; l < LANES; l++)
        over_thr[t][l] = err_cnt[t][l] >= shared_error_threshold;
  end

  always_ff @(posedge sys_clk) begin
    for (int t = 0; t < 3; t++) begin
      for (int l = 0; l < LANES; l++) begin
        if (sys_rst) begin
          err_cnt[t][l] <= 8'h00;
        end else if (ctl_hit && ctl_off == 12'(t) && ctl_lane == 3'(l) &&
                     reg_wdata[`SLTEM_RST_CNT_BIT]) begin
          err_cnt[t][l] <= 8'h00;
        end else if (err_in[t][l] && !cnt_disable[t][l] &&
                     !over_thr[t][l]) begin
          err_cnt[t][l] <= err_cnt[t][l] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int t = 0; t < 3; t++) begin
      for (int l = 0; l < LANES; l++) begin
        if (sys_rst) begin
          cnt_disable[t][l] <= 1'b0;
        end else if (ctl_hit && ctl_off == 12'(t) && ctl_lane == 3'(l)) begin
          cnt_disable[t][l] <= reg_wdata[`SLTEM_DIS_CNT_BIT];
        end
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    for (int t = 0; t < 3; t++) begin
      for (int l = 0; l < LANES; l++) begin
        if (sys_rst)
          lane_irq[t][l] <= 1'b0;
        else if (irq_enable[2-t] && over_thr[t][l])
          lane_irq[t][l] <= 1'b1;
        else if (ctl_hit && ctl_off == 12'(t) && ctl_lane == 3'(l) &&
                 reg_wdata[`SLTEM_RST_IRQ_BIT])
          lane_irq[t][l] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  logic [2:0] prbs_sel;
  logic [2:0] cnt_lane;
  logic [1:0] cnt_type;

  assign prbs_sel = prbs_test_control[6:4];
  assign cnt_lane = map_lane(link_page, count_sel[6:4]);
  assign cnt_type = (count_sel[1:0] == 2'b11) ? 2'b00 : count_sel[1:0];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `SLTEM_LINK_PAGE:  reg_rdata <= {5'h0, link_page, 2'b00};
        `SLTEM_PRBS_EN:    reg_rdata <= prbs_lane_enable;
        `SLTEM_PRBS_CTRL:  reg_rdata <= prbs_test_control;
        `SLTEM_PRBS_LIM0:  reg_rdata <= prbs_error_limit[7:0];
        `SLTEM_PRBS_LIM1:  reg_rdata <= prbs_error_limit[15:8];
        `SLTEM_PRBS_LIM2:  reg_rdata <= prbs_error_limit[23:16];
        `SLTEM_PRBS_CNT0:  reg_rdata <= prbs_error_count[prbs_sel][7:0];
        `SLTEM_PRBS_CNT1:  reg_rdata <= prbs_error_count[prbs_sel][15:8];
        `SLTEM_PRBS_CNT2:  reg_rdata <= prbs_error_count[prbs_sel][23:16];
        `SLTEM_PRBS_PASS:  reg_rdata <= prbs_lane_pass;
        `SLTEM_TPL_CTRL:   reg_rdata <= transport_test_control;
        `SLTEM_TPL_EXP_LO: reg_rdata <= transport_expected_sample[7:0];
        `SLTEM_TPL_EXP_HI: reg_rdata <= transport_expected_sample[15:8];
        `SLTEM_TPL_RESULT: reg_rdata <= {7'h0, transport_test_mismatch};
        `SLTEM_CNT_SEL:    reg_rdata <= err_cnt[cnt_type][cnt_lane];
        `SLTEM_OVER_DISP:  reg_rdata <= page_view(link_page, over_thr[0]);
        `SLTEM_OVER_NIT:   reg_rdata <= page_view(link_page, over_thr[1]);
        `SLTEM_OVER_UCC:   reg_rdata <= page_view(link_page, over_thr[2]);
        `SLTEM_CGS_FLAGS:  reg_rdata <= page_view(link_page, cgs_pass);
        `SLTEM_ILAS_MODE:  reg_rdata <= {ilas_test_mode, 7'h0};
        `SLTEM_IRQ_EN:     reg_rdata <= {|lane_irq[0], |lane_irq[1],
                                         |lane_irq[2], 5'h00};
        `SLTEM_ERR_THR:    reg_rdata <= shared_error_threshold;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence run_ends;
    prbs_running && !start_bit && !prbs_clear;
  endsequence
  sequence cgs_done;
    link_enable && &(cgs_pass | ~lane_in_use);
  endsequence

  prbs_sat_a: assert property (
    prbs_error_count[0] == `SLTEM_PRBS_MAX && !prbs_clear
    |=> prbs_error_count[0] == `SLTEM_PRBS_MAX)
    else $error("prbs count left saturation");
  prbs_pass_a: assert property (
    run_ends |=> prbs_lane_pass[0] ==
      ($past(prbs_error_count[0]) <= $past(prbs_error_limit)))
    else $error("pass bit wrong at run end");
  prbs_clear_a: assert property (
    prbs_clear |=> prbs_error_count[1] == 24'h0 && prbs_lane_pass == 8'h00)
    else $error("clear did not wipe checker");
  run_start_a: assert property (
    start_bit && !start_q && !prbs_clear |=> prbs_running)
    else $error("run did not start");
  prbs_idle_a: assert property (
    !prbs_lane_enable[2] && !prbs_clear |=> $stable(prbs_error_count[2]))
    else $error("disabled lane counted");
  tpl_fail_a: assert property (
    tpl_enable && !tpl_clear && tpl_valid &&
    tpl_conv == transport_test_control[3:2] &&
    tpl_slot == transport_test_control[5:4] &&
    tpl_sample != transport_expected_sample
    |=> transport_test_mismatch ##1 (transport_test_mismatch || $past(tpl_clear)))
    else $error("mismatch not flagged");
  err_stop_a: assert property (
    over_thr[0][0] && !ctl_hit |=> $stable(err_cnt[0][0]))
    else $error("counter passed threshold");
  irq_hold_a: assert property (
    irq_enable[2] && over_thr[0][2] |=> lane_irq[0][2])
    else $error("disparity irq not set");
  sync_rel_a: assert property (
    cgs_done |=> sync_request_output_n)
    else $error("sync not released");
  sync_hold_a: assert property (
    !link_enable |=> !sync_request_output_n && comma_cnt[0] == 3'h0)
    else $error("sync released without link");
endmodule

//--- hdl/sltem_regs.svh
// Register offsets, field positions and reset values of the test monitor
`ifndef SLTEM_REGS_SVH
`define SLTEM_REGS_SVH
`define SLTEM_LINK_PAGE      12'h300
`define SLTEM_PRBS_EN        12'h315
`define SLTEM_PRBS_CTRL      12'h316
`define SLTEM_PRBS_LIM0      12'h317
`define SLTEM_PRBS_LIM1      12'h318
`define SLTEM_PRBS_LIM2      12'h319
`define SLTEM_PRBS_CNT0      12'h31A
`define SLTEM_PRBS_CNT1      12'h31B
`define SLTEM_PRBS_CNT2      12'h31C
`define SLTEM_PRBS_PASS      12'h31D
`define SLTEM_TPL_CTRL       12'h32C
`define SLTEM_TPL_EXP_LO     12'h32D
`define SLTEM_TPL_EXP_HI     12'h32E
`define SLTEM_TPL_RESULT     12'h32F
`define SLTEM_CNT_SEL        12'h46B
`define SLTEM_OVER_DISP      12'h46D
`define SLTEM_OVER_NIT       12'h46E
`define SLTEM_OVER_UCC       12'h46F
`define SLTEM_CGS_FLAGS      12'h470
`define SLTEM_ILAS_MODE      12'h477
`define SLTEM_IRQ_EN         12'h47A
`define SLTEM_ERR_THR        12'h47C
`define SLTEM_PAGE_BIT       2
`define SLTEM_CLR_BIT        0
`define SLTEM_START_BIT      1
`define SLTEM_ILAS_BIT       7
`define SLTEM_RST_IRQ_BIT    7
`define SLTEM_DIS_CNT_BIT    6
`define SLTEM_RST_CNT_BIT    5
`define SLTEM_THR_RESET      8'hFF
`define SLTEM_PRBS_MAX       24'hFFFFFF
`define SLTEM_SEED_BITS      5'h1F
`define SLTEM_COMMA_NEED     3'h4
`endif

//--- hdl/sltem_pkg.sv
// Types shared by the test and error monitor
package sltem_pkg;
  typedef enum logic [1:0] {
    SLTEM_PAT7  = 2'b00,
    SLTEM_PAT15 = 2'b01,
    SLTEM_PAT31 = 2'b10
  } sltem_pat_t;
  typedef enum logic [1:0] {
    SLTEM_ERR_DISP = 2'b00,
    SLTEM_ERR_NIT  = 2'b01,
    SLTEM_ERR_UCC  = 2'b10
  } sltem_err_t;
  typedef logic [7:0] sltem_byte_t;
endpackage

//--- verif/sltem_tx_model.sv
// Transmitter model: raw PRBS lanes, transport samples, comma stream
`timescale 1ns/1ps

module sltem_tx_model (
  input  wire logic [1:0] pat_sel,
  input  wire logic       sys_clk,
  input  wire logic [7:0] flip_mask,
  input  wire logic       cgs_go,
  input  wire logic       sync_n,
  input  wire logic       ilas_mode,
  output logic [7:0]      lane_bit,
  output logic [15:0]     tpl_sample,
  output logic [1:0]      tpl_conv,
  output logic [1:0]      tpl_slot,
  output logic            tpl_valid,
  output logic [7:0]      comma_seen
);
  logic [30:0] lfsr;
  logic [3:0]  pos;
  logic [7:0]  flip;
  logic        go;
  logic        fb;

  initial begin
    lfsr = 31'h00000001;
    pos = 4'h0;
    lane_bit = 8'h00;
    tpl_sample = 16'h0000;
    tpl_conv = 2'h0;
    tpl_slot = 2'h0;
    tpl_valid = 1'h0;
    comma_seen = 8'h00;
  end

  // Controls sampled at the edge, outputs moved just after it
  always @(posedge sys_clk) begin
    flip = flip_mask;
    go = cgs_go;
    #1;
    case (pat_sel)
      2'h0:    fb = lfsr[6] ^ lfsr[5];
      2'h1:    fb = lfsr[14] ^ lfsr[13];
      default: fb = lfsr[30] ^ lfsr[27];
    endcase
    lfsr = {lfsr[29:0], fb};
    // Free-running pattern, no link needed; flips are forced bit errors
    lane_bit = {8{fb}} ^ flip;
    // Every slot repeats with its own value
    pos = pos + 4'h1;
    tpl_conv = pos[3:2];
    tpl_slot = pos[1:0];
    tpl_valid = 1'h1;
    tpl_sample = 16'h1000 + 16'h0111 * {12'h000, pos};
    // Commas while go; in ILAS mode they stop once sync is released
    comma_seen = (go && !(sync_n && ilas_mode)) ? 8'hFF : 8'h00;
  end
endmodule

//--- verif/serial_link_test_error_monitor_test.sv
// Self-checking bench for the serial link test and error monitor
`timescale 1ns/1ps

module serial_link_test_error_monitor_test;
  import sltem_pkg::*;

  logic        sys_clk;
  logic        sys_rst;
  logic [11:0] reg_addr;
  logic        reg_wr;
  sltem_byte_t reg_wdata;
  sltem_byte_t reg_rdata;
  logic [7:0]  lane_bit;
  logic [7:0]  disp_err;
  logic [7:0]  nit_err;
  logic [7:0]  ucc_err;
  logic [15:0] tpl_sample;
  logic [1:0]  tpl_conv;
  logic [1:0]  tpl_slot;
  logic        tpl_valid;
  logic [7:0]  comma_seen;
  logic [7:0]  lane_in_use;
  logic        link_enable;
  logic        sync_request_output_n;
  logic        ilas_test_mode;
  logic [1:0]  pat_sel;
  logic [7:0]  flip_mask;
  logic        cgs_go;
  int          num_errors;
  int          checks_done;

  sltem_monitor u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .lane_bit, .disp_err, .nit_err, .ucc_err, .tpl_sample,
    .tpl_conv, .tpl_slot, .tpl_valid, .comma_seen, .lane_in_use,
    .link_enable, .sync_request_output_n, .ilas_test_mode);
  sltem_tx_model u_tx (.sys_clk, .pat_sel, .flip_mask, .cgs_go,
    .sync_n(sync_request_output_n), .ilas_mode(ilas_test_mode), .lane_bit,
    .tpl_sample, .tpl_conv, .tpl_slot, .tpl_valid, .comma_seen);

  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input sltem_byte_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    tick(1);
    reg_wr = 1'h0;
    tick(1);
  endtask
  task automatic rd(input logic [11:0] a, output sltem_byte_t d);
    reg_addr = a;
    tick(1);
    d = reg_rdata;
  endtask
  task automatic check_count(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input sltem_byte_t got, input sltem_byte_t exp);
    check_count({16'h0000, got}, {16'h0000, exp});
  endtask
  task automatic check_pin(input logic got, input logic exp);
    check_count({23'h000000, got}, {23'h000000, exp});
  endtask
  task automatic expect_reg(input logic [11:0] a, input sltem_byte_t m,
                            input sltem_byte_t e);
    sltem_byte_t d;
    rd(a, d);
    check_byte(d & m, e);
  endtask
  task automatic finish_test();
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    expect_reg(12'h47C, 8'hFF, 8'hFF);
    expect_reg(12'h31D, 8'hFF, 8'h00);
    wr(12'h3FF, 8'h5A);
    expect_reg(12'h3FF, 8'hFF, 8'h00);
    check_pin(sync_request_output_n, 1'h0);
  endtask

  // Errors go to lane 1 (na) and lane 2 (nb), one forced bit every other cycle
  task automatic prbs_run(input logic [1:0] pat, input logic [23:0] lim,
                          input int na, input int nb);
    pat_sel = pat;
    wr(12'h315, 8'h0F);
    wr(12'h316, {4'h0, pat, 2'h0});
    tick(40);
    wr(12'h316, {4'h0, pat, 2'h1});
    wr(12'h316, {4'h0, pat, 2'h0});
    wr(12'h317, lim[7:0]);
    wr(12'h318, lim[15:8]);
    wr(12'h319, lim[23:16]);
    wr(12'h316, {4'h0, pat, 2'h2});
    tick(40);
    for (int i = 0; i < na; i++) begin
      flip_mask = (i < nb) ? 8'h06 : 8'h02;
      tick(1);
      flip_mask = 8'h00;
      tick(1);
    end
    tick(5);
    wr(12'h316, {4'h0, pat, 2'h0});
  endtask
  task automatic prbs_count_is(input logic [2:0] ln, input logic [1:0] pat,
                               input logic [23:0] e);
    sltem_byte_t b0, b1, b2;
    wr(12'h316, {1'h0, ln, pat, 2'h0});
    rd(12'h31A, b0);
    rd(12'h31B, b1);
    rd(12'h31C, b2);
    check_count({b2, b1, b0}, e);
  endtask
  task automatic test_prbs_fail();
    prbs_run(2'h0, 24'h000005, 10, 3);
    expect_reg(12'h31D, 8'hFF, 8'hFD);
    prbs_count_is(3'h1, 2'h0, 24'h00000A);
    prbs_count_is(3'h2, 2'h0, 24'h000003);
    prbs_count_is(3'h0, 2'h0, 24'h000000);
  endtask
  task automatic test_prbs_patterns();
    for (int p = 0; p < 3; p++) begin
      prbs_run(p[1:0], 24'h010000, 4 + p, 0);
      expect_reg(12'h31D, 8'hFF, 8'hFF);
      prbs_count_is(3'h1, p[1:0], 24'h000004 + p[23:0]);
    end
  endtask

  task automatic tpl_case(input logic [1:0] c, input logic [1:0] s,
                          input logic [15:0] e, input sltem_byte_t res);
    wr(12'h32D, e[7:0]);
    wr(12'h32E, e[15:8]);
    wr(12'h32C, {2'h0, s, c, 2'h1});
    wr(12'h32C, {2'h0, s, c, 2'h3});
    wr(12'h32C, {2'h0, s, c, 2'h1});
    tick(20);
    expect_reg(12'h32F, 8'h01, res);
  endtask
  task automatic test_transport();
    tpl_case(2'h0, 2'h0, 16'h1000, 8'h00);
    tpl_case(2'h3, 2'h2, 16'h1EEE, 8'h00);
    tpl_case(2'h1, 2'h2, 16'h1667, 8'h01);
    tpl_case(2'h1, 2'h2, 16'h1766, 8'h01);
    tpl_case(2'h2, 2'h1, 16'h1666, 8'h01);
  endtask

  task automatic test_cgs();
    wr(12'h477, 8'h80);
    check_pin(ilas_test_mode, 1'h1);
    lane_in_use = 8'hFF;
    link_enable = 1'h1;
    cgs_go = 1'h1;
    tick(3);
    cgs_go = 1'h0;
    tick(4);
    check_pin(sync_request_output_n, 1'h0);
    cgs_go = 1'h1;
    tick(1);
    cgs_go = 1'h0;
    tick(4);
    check_pin(sync_request_output_n, 1'h1);
    expect_reg(12'h470, 8'hFF, 8'hFF);
    wr(12'h300, 8'h04);
    expect_reg(12'h470, 8'h0F, 8'h0F);
    wr(12'h300, 8'h00);
    link_enable = 1'h0;
    tick(3);
    check_pin(sync_request_output_n, 1'h0);
    wr(12'h477, 8'h00);
    link_enable = 1'h1;
    cgs_go = 1'h1;
    tick(8);
    check_pin(sync_request_output_n, 1'h1);
    cgs_go = 1'h0;
  endtask

  task automatic pulse_err(input int kind, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      case (kind)
        0:       disp_err = m;
        1:       nit_err = m;
        default: ucc_err = m;
      endcase
      tick(1);
      disp_err = 8'h00;
      nit_err = 8'h00;
      ucc_err = 8'h00;
      tick(1);
    end
  endtask
  task automatic cnt_is(input logic [2:0] ln, input logic [1:0] typ,
                        input sltem_byte_t e);
    wr(12'h46B, {1'h0, ln, 2'h0, typ});
    expect_reg(12'h46B, 8'hFF, e);
  endtask
  task automatic test_errors();
    wr(12'h47C, 8'h03);
    pulse_err(0, 8'h04, 5);
    pulse_err(1, 8'h20, 2);
    pulse_err(2, 8'h01, 3);
    cnt_is(3'h2, 2'h0, 8'h03);
    cnt_is(3'h5, 2'h1, 8'h02);
    cnt_is(3'h0, 2'h2, 8'h03);
    cnt_is(3'h5, 2'h0, 8'h00);
    expect_reg(12'h46D, 8'hFF, 8'h04);
    expect_reg(12'h46E, 8'hFF, 8'h00);
    expect_reg(12'h46F, 8'hFF, 8'h01);
    wr(12'h47A, 8'hE0);
    expect_reg(12'h47A, 8'hE0, 8'hA0);
    wr(12'h46D, 8'h22);
    cnt_is(3'h2, 2'h0, 8'h00);
    expect_reg(12'h46D, 8'hFF, 8'h00);
    wr(12'h46D, 8'h82);
    expect_reg(12'h47A, 8'hE0, 8'h20);
    wr(12'h46D, 8'h43);
    pulse_err(0, 8'h08, 2);
    cnt_is(3'h3, 2'h0, 8'h00);
    wr(12'h46D, 8'h03);
    pulse_err(0, 8'h08, 1);
    cnt_is(3'h3, 2'h0, 8'h01);
    wr(12'h300, 8'h04);
    cnt_is(3'h1, 2'h1, 8'h02);
    wr(12'h300, 8'h00);
  endtask

  initial begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    reg_addr = 12'h000;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    disp_err = 8'h00;
    nit_err = 8'h00;
    ucc_err = 8'h00;
    lane_in_use = 8'h00;
    link_enable = 1'h0;
    pat_sel = 2'h0;
    flip_mask = 8'h00;
    cgs_go = 1'h0;
    num_errors = 0;
    checks_done = 0;
    tick(10);
    sys_rst = 1'h0;
    tick(1);
    test_reset();
    test_prbs_fail();
    test_prbs_patterns();
    test_transport();
    test_cgs();
    test_errors();
    finish_test();
  end

  // Whole run needs under a thousand cycles; allow far more
  initial begin
    #(40 * 20000);
    num_errors++;
    finish_test();
  end
endmodule
